// File: src/trail_trace_pkg.sv
// Contract
// - Transmit bit order follows transmit reorder setting
// - Optional alignment: byte one one, others zero
// - Transmit inversion after reorder and alignment
// - Transmit idle sends all zeros
// - Receive inversion before all receive processing
// - Hunt start bit, verify fifteen zero bits
// - No alignment: store from arbitrary byte
// - Start byte goes to first memory location
// - Five identical new non-zero identifiers update
// - Idle after five zero, ends nonzero/unstable
// - Unstable after eight unmatched, ends five/idle
// - Mismatch compares seven data bits only
// - Programmable expected, compare off without alignment
// - No comparison before first accepted update
// - Receive bit order follows receive reorder setting
// - Current, accepted, expected all readable
// - Line defects force receive data to ones
// - Transmit identifier untouched by reset
package trail_trace_pkg;
  localparam int ID_LEN = 16;
  // Register byte offsets
  localparam logic [9:0] CTRL_OFS = 10'h000;
  localparam logic [9:0] STATUS_OFS = 10'h004;
  localparam logic [9:0] EVENT_OFS = 10'h008;
  // Memory regions selected by address bits 8:6
  localparam logic [2:0] REG_REGION = 3'h0;
  localparam logic [2:0] TX_REGION = 3'h1;
  localparam logic [2:0] CUR_REGION = 3'h2;
  localparam logic [2:0] ACC_REGION = 3'h3;
  localparam logic [2:0] EXP_REGION = 3'h4;
  // Control bit positions
  localparam int C_TX_REORDER = 0;
  localparam int C_TX_ALIGN = 1;
  localparam int C_TX_INVERT = 2;
  localparam int C_TX_IDLE = 3;
  localparam int C_RX_INVERT = 4;
  localparam int C_RX_ALIGN = 5;
  localparam int C_RX_REORDER = 6;
  localparam int C_CMP_EN = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Status and event bit positions
  localparam int S_CHANGE = 0;
  localparam int S_IDLE = 1;
  localparam int S_UNSTABLE = 2;
  localparam int S_MISMATCH = 3;
  localparam int S_VALID = 4;
  localparam int S_LOCKED = 5;
  // Persistence counts
  localparam logic [3:0] N_UPDATE = 4'h5;
  localparam logic [3:0] N_IDLE = 4'h5;
  localparam logic [3:0] N_NONZERO = 4'h5;
  localparam logic [3:0] N_UNSTABLE = 4'h8;
  localparam logic [3:0] CNT_MAX = 4'hF;
  // Data bit masks for stored bytes
  localparam logic [7:0] DATA_MASK = 8'h7F;
  localparam logic [7:0] DATA_MASK_REV = 8'hFE;
  typedef enum logic {RX_HUNT, RX_LOCK} rx_state_e;
endpackage : trail_trace_pkg

// File: src/trail_trace_processor.sv
// The Wishbone register port and the placing of the registers were left to the implementer.
module trail_trace_processor (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Transmit trace stream
  input wire logic tx_bit_req_i,
  output logic tx_bit_o,
  // Receive trace stream
  input wire logic rx_bit_valid_i,
  input wire logic rx_first_bit_i,
  input wire logic rx_bit_i,
  input wire logic rx_defect_i
);
  localparam int L = trail_trace_pkg::ID_LEN;

  // Reverses the bit order of a byte
  function automatic logic [7:0] rev8(input logic [7:0] b);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = b[7 - i];
    end
    return r;
  endfunction : rev8

  logic [7:0] ctrl_q;
  logic [7:0] tx_mem [L];
  logic [7:0] cur_mem [L];
  logic [7:0] acc_mem [L];
  logic [7:0] exp_mem [L];

  // Bus decode
  logic req;
  logic wr;
  logic [2:0] region;
  logic [3:0] widx;
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i & wb_sel_i[0];
  // Upper half of the map is unmapped, steered to an empty region
  assign region = wb_adr_i[9] ? 3'h7 : wb_adr_i[8:6];
  assign widx = wb_adr_i[5:2];

  // Bus answers one cycle after request, then drops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // Control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= trail_trace_pkg::CTRL_RESET;
    end else if (wr && region == trail_trace_pkg::REG_REGION &&
                 wb_adr_i[5:0] == trail_trace_pkg::CTRL_OFS[5:0]) begin
      ctrl_q <= wb_dat_i[7:0];
    end
  end

  // Transmit identifier store, no reset
  always_ff @(posedge clk_i) begin
    if (wr && region == trail_trace_pkg::TX_REGION) begin
      tx_mem[widx] <= wb_dat_i[7:0];
    end
  end

  // Expected identifier store
  always_ff @(posedge clk_i) begin
    if (wr && region == trail_trace_pkg::EXP_REGION) begin
      exp_mem[widx] <= wb_dat_i[7:0];
    end
  end

  // Transmit serializer
  logic [3:0] tx_byte_q;
  logic [2:0] tx_bitn_q;
  logic [7:0] tx_sig;
  logic tx_d;
  always_comb begin
    tx_sig = ctrl_q[trail_trace_pkg::C_TX_REORDER] ? rev8(tx_mem[tx_byte_q])
                                                   : tx_mem[tx_byte_q];
    tx_d = tx_sig[3'd7 - tx_bitn_q];
    if (ctrl_q[trail_trace_pkg::C_TX_ALIGN] && tx_bitn_q == 3'd0) begin
      tx_d = (tx_byte_q == 4'h0);
    end
    if (ctrl_q[trail_trace_pkg::C_TX_INVERT]) begin
      tx_d = ~tx_d;
    end
    if (ctrl_q[trail_trace_pkg::C_TX_IDLE]) begin
      tx_d = 1'b0;
    end
  end

  // Transmit position and output bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_byte_q <= 4'h0;
      tx_bitn_q <= 3'd0;
      tx_bit_o <= 1'b0;
    end else if (tx_bit_req_i) begin
      tx_bit_o <= tx_d;
      tx_bitn_q <= tx_bitn_q + 3'd1;
      if (tx_bitn_q == 3'd7) begin
        tx_byte_q <= tx_byte_q + 4'h1;
      end
    end
  end

  // Receive bit conditioning and byte assembly
  logic rx_b;
  logic [2:0] rx_pos;
  logic [7:0] rx_sr_d;
  logic byte_done;
  logic [2:0] rx_cnt_q;
  logic [7:0] rx_sr_q;
  logic align_en;
  logic [7:0] dmask;
  logic [7:0] rx_store;
  assign align_en = ctrl_q[trail_trace_pkg::C_RX_ALIGN];
  assign rx_b = rx_defect_i ? 1'b1 : (rx_bit_i ^ ctrl_q[trail_trace_pkg::C_RX_INVERT]);
  assign rx_pos = rx_first_bit_i ? 3'd0 : rx_cnt_q;
  assign rx_sr_d = {rx_sr_q[6:0], rx_b};
  assign byte_done = rx_bit_valid_i && rx_pos == 3'd7;
  assign rx_store = ctrl_q[trail_trace_pkg::C_RX_REORDER] ? rev8(rx_sr_d) : rx_sr_d;
  assign dmask = ctrl_q[trail_trace_pkg::C_RX_REORDER] ? trail_trace_pkg::DATA_MASK_REV
                                                        : trail_trace_pkg::DATA_MASK;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_cnt_q <= 3'd0;
      rx_sr_q <= 8'h00;
    end else if (rx_bit_valid_i) begin
      rx_cnt_q <= rx_pos + 3'd1;
      rx_sr_q <= rx_sr_d;
    end
  end

  // Alignment decision per byte
  trail_trace_pkg::rx_state_e rx_state_q;
  logic [3:0] rx_idx_q;
  logic start_byte;
  logic store;
  logic [3:0] st_idx;
  logic id_done;
  always_comb begin
    start_byte = align_en && rx_sr_d[7];
    store = byte_done;
    st_idx = rx_idx_q;
    if (align_en) begin
      if (start_byte && (rx_state_q == trail_trace_pkg::RX_HUNT || rx_idx_q != 4'h0)) begin
        st_idx = 4'h0;
      end else if (!start_byte &&
                   (rx_state_q == trail_trace_pkg::RX_HUNT || rx_idx_q == 4'h0)) begin
        store = 1'b0;
      end
    end
  end
  assign id_done = store && st_idx == 4'hF;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_state_q <= trail_trace_pkg::RX_HUNT;
      rx_idx_q <= 4'h0;
    end else if (byte_done) begin
      if (!align_en) begin
        rx_idx_q <= rx_idx_q + 4'h1;
        rx_state_q <= trail_trace_pkg::RX_HUNT;
      end else if (store) begin
        rx_idx_q <= st_idx + 4'h1;
        rx_state_q <= trail_trace_pkg::RX_LOCK;
      end else begin
        rx_idx_q <= 4'h0;
        rx_state_q <= trail_trace_pkg::RX_HUNT;
      end
    end
  end

  // Running per-identifier match flags
  logic eq_cur_q;
  logic eq_acc_q;
  logic zero_q;
  logic eq_cur_n;
  logic eq_acc_n;
  logic zero_n;
  logic first;
  logic acc_valid_q;
  assign first = st_idx == 4'h0;
  assign eq_cur_n = (first | eq_cur_q) & (rx_store == cur_mem[st_idx]);
  assign eq_acc_n = (first | eq_acc_q) & acc_valid_q & (rx_store == acc_mem[st_idx]);
  assign zero_n = (first | zero_q) &
                  ((rx_store & (align_en ? dmask : 8'hFF)) == 8'h00);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eq_cur_q <= 1'b0;
      eq_acc_q <= 1'b0;
      zero_q <= 1'b0;
    end else if (store) begin
      eq_cur_q <= eq_cur_n;
      eq_acc_q <= eq_acc_n;
      zero_q <= zero_n;
    end
  end

  // Current identifier store
  always_ff @(posedge clk_i) begin
    if (store) begin
      cur_mem[st_idx] <= rx_store;
    end
  end

  // Persistence counters
  logic [3:0] rep_q;
  logic [3:0] zcnt_q;
  logic [3:0] nzcnt_q;
  logic [3:0] ucnt_q;
  logic [3:0] rep_n;
  logic [3:0] zcnt_n;
  logic [3:0] nzcnt_n;
  logic [3:0] ucnt_n;
  logic sat_rep;
  assign sat_rep = rep_q == trail_trace_pkg::CNT_MAX;
  assign rep_n = eq_cur_n ? (sat_rep ? rep_q : rep_q + 4'h1) : 4'h1;
  assign zcnt_n = zero_n ? (zcnt_q == trail_trace_pkg::CNT_MAX ? zcnt_q : zcnt_q + 4'h1)
                         : 4'h0;
  assign nzcnt_n = !zero_n ? (nzcnt_q == trail_trace_pkg::CNT_MAX ? nzcnt_q : nzcnt_q + 4'h1)
                           : 4'h0;
  assign ucnt_n = (!eq_cur_n && !eq_acc_n) ?
                  (ucnt_q == trail_trace_pkg::CNT_MAX ? ucnt_q : ucnt_q + 4'h1) : 4'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rep_q <= 4'h0;
      zcnt_q <= 4'h0;
      nzcnt_q <= 4'h0;
      ucnt_q <= 4'h0;
    end else if (id_done) begin
      rep_q <= rep_n;
      zcnt_q <= zcnt_n;
      nzcnt_q <= nzcnt_n;
      ucnt_q <= ucnt_n;
    end
  end

  // Update decision, copied one cycle later once last byte is stored
  logic upd_go;
  logic upd_pend_q;
  assign upd_go = id_done && !zero_n && !eq_acc_n && rep_n >= trail_trace_pkg::N_UPDATE;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      upd_pend_q <= 1'b0;
      acc_valid_q <= 1'b0;
    end else begin
      upd_pend_q <= upd_go;
      if (upd_pend_q) begin
        acc_valid_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (upd_pend_q) begin
      for (int i = 0; i < L; i++) begin
        acc_mem[i] <= cur_mem[i];
      end
    end
  end

  // Idle and unstable conditions
  logic idle_q;
  logic unst_q;
  logic idle_set;
  logic unst_set;
  logic nz_end;
  assign idle_set = id_done && zcnt_n == trail_trace_pkg::N_IDLE;
  assign unst_set = id_done && ucnt_n == trail_trace_pkg::N_UNSTABLE;
  assign nz_end = id_done && nzcnt_n == trail_trace_pkg::N_NONZERO;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idle_q <= 1'b0;
      unst_q <= 1'b0;
    end else begin
      if (idle_set) begin
        idle_q <= 1'b1;
      end else if (nz_end || unst_set) begin
        idle_q <= 1'b0;
      end
      if (unst_set && !idle_set) begin
        unst_q <= 1'b1;
      end else if (nz_end || idle_set) begin
        unst_q <= 1'b0;
      end
    end
  end

  // Expected comparison on seven data bits
  logic cmp_act;
  logic mis_n;
  logic mis_q;
  assign cmp_act = ctrl_q[trail_trace_pkg::C_CMP_EN] && align_en && acc_valid_q;
  always_comb begin
    mis_n = 1'b0;
    for (int i = 0; i < L; i++) begin
      if (((acc_mem[i] ^ exp_mem[i]) & dmask) != 8'h00) begin
        mis_n = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mis_q <= 1'b0;
    end else begin
      mis_q <= cmp_act && mis_n;
    end
  end

  // Latched event flags, set wins over write-one clear
  logic [3:0] ev_q;
  logic [3:0] ev_set;
  logic idle_prev_q;
  logic unst_prev_q;
  logic mis_prev_q;
  logic ev_clr;
  assign ev_set = {mis_q ^ mis_prev_q, unst_q ^ unst_prev_q, idle_q ^ idle_prev_q, upd_pend_q};
  assign ev_clr = wr && region == trail_trace_pkg::REG_REGION &&
                  wb_adr_i[5:0] == trail_trace_pkg::EVENT_OFS[5:0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_q <= 4'h0;
      idle_prev_q <= 1'b0;
      unst_prev_q <= 1'b0;
      mis_prev_q <= 1'b0;
    end else begin
      idle_prev_q <= idle_q;
      unst_prev_q <= unst_q;
      mis_prev_q <= mis_q;
      ev_q <= (ev_q & ~(ev_clr ? wb_dat_i[3:0] : 4'h0)) | ev_set;
    end
  end

  // Read data mux, unmapped reads return zero
  logic [31:0] rd;
  always_comb begin
    rd = 32'h0000_0000;
    unique case (region)
      trail_trace_pkg::REG_REGION: begin
        if (wb_adr_i[5:0] == trail_trace_pkg::CTRL_OFS[5:0]) begin
          rd = {24'h00_0000, ctrl_q};
        end else if (wb_adr_i[5:0] == trail_trace_pkg::STATUS_OFS[5:0]) begin
          rd = {26'h000_0000, rx_state_q == trail_trace_pkg::RX_LOCK, acc_valid_q,
                mis_q, unst_q, idle_q, 1'b0};
        end else if (wb_adr_i[5:0] == trail_trace_pkg::EVENT_OFS[5:0]) begin
          rd = {28'h000_0000, ev_q};
        end
      end
      trail_trace_pkg::TX_REGION: rd = {24'h00_0000, tx_mem[widx]};
      trail_trace_pkg::CUR_REGION: rd = {24'h00_0000, cur_mem[widx]};
      trail_trace_pkg::ACC_REGION: rd = {24'h00_0000, acc_mem[widx]};
      trail_trace_pkg::EXP_REGION: rd = {24'h00_0000, exp_mem[widx]};
      default: rd = 32'h0000_0000;
    endcase
    if (wb_adr_i[9]) begin
      rd = 32'h0000_0000;
    end
  end

  // Registered read data; bus access never stalls line logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= rd;
    end
  end
endmodule : trail_trace_processor

// File: tb/trace_properties.sv
module trace_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic tx_bit_req_i,
  input wire logic tx_bit_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ctrl_q;
  logic [6:0] txc_q;
  logic take;
  logic first;
  // Request taken, expected first bit of a byte
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign first = (txc_q == 7'h00) ^ ctrl_q[trail_trace_pkg::C_TX_INVERT];
  // Shadow of control and transmit bit count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= 8'h00;
      txc_q <= 7'h00;
    end else begin
      if (take && wb_we_i && wb_sel_i[0] && wb_adr_i == trail_trace_pkg::CTRL_OFS) begin
        ctrl_q <= wb_dat_i[7:0];
      end
      if (tx_bit_req_i) begin
        txc_q <= txc_q + 7'h01;
      end
    end
  end
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ack_take_a: assert property (take |=> wb_ack_o)
    else $error("request not acked");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  ack_cause_a: assert property (!take |=> !wb_ack_o)
    else $error("ack without request");
  tx_hold_a: assert property (!tx_bit_req_i |=> $stable(tx_bit_o))
    else $error("tx bit moved unasked");
  tx_idle_a: assert property (tx_bit_req_i && ctrl_q[trail_trace_pkg::C_TX_IDLE] |=> !tx_bit_o)
    else $error("idle bit not zero");
  tx_align_a: assert property (tx_bit_req_i && ctrl_q[trail_trace_pkg::C_TX_ALIGN] &&
    !ctrl_q[trail_trace_pkg::C_TX_IDLE] && txc_q[2:0] == 3'h0 |=> tx_bit_o == $past(first))
    else $error("alignment bit wrong");
  ctrl_read_a: assert property (take && !wb_we_i && wb_adr_i == trail_trace_pkg::CTRL_OFS
    |=> wb_dat_o == {24'h00_0000, ctrl_q}) else $error("control readback wrong");
  hole_read_a: assert property (take && !wb_we_i && wb_adr_i[9] |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  cmp_off_a: assert property (take && !wb_we_i && wb_adr_i == trail_trace_pkg::STATUS_OFS &&
    !(ctrl_q[trail_trace_pkg::C_CMP_EN] && ctrl_q[trail_trace_pkg::C_RX_ALIGN])
    |=> !wb_dat_o[trail_trace_pkg::S_MISMATCH]) else $error("mismatch while compare off");
endmodule : trace_checker

bind trail_trace_processor trace_checker chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .tx_bit_req_i, .tx_bit_o);

// File: tb/trace_framer_model.sv
module trace_framer_model (
  input wire logic clk_i,
  input wire logic tx_bit_i,
  output logic tx_bit_req_o,
  output logic rx_bit_valid_o,
  output logic rx_first_bit_o,
  output logic rx_bit_o,
  output logic [7:0] tx_byte_o,
  output logic tx_byte_v_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic taken_q = 1'b0;
  logic [2:0] cnt_q = 3'h0;
  logic [7:0] sh_q = 8'h00;
  // Idle lines at time zero
  initial begin
    tx_bit_req_o = 1'b0;
    rx_bit_valid_o = 1'b0;
    rx_first_bit_o = 1'b0;
    rx_bit_o = 1'b0;
    tx_byte_v_o = 1'b0;
  end
  // Collect each bit the cycle after its request, first bit into bit 7
  always @(posedge clk_i) begin
    taken_q <= tx_bit_req_o;
    tx_byte_v_o <= 1'b0;
    if (taken_q) begin
      sh_q <= {sh_q[6:0], tx_bit_i};
      cnt_q <= cnt_q + 3'h1;
      tx_byte_o <= {sh_q[6:0], tx_bit_i};
      tx_byte_v_o <= (cnt_q == 3'h7);
    end
  end
  // One identifier of requests, back to back with a pause every fifth
  task automatic tx_ident();
    for (int i = 0; i < 128; i++) begin
      tx_bit_req_o <= 1'b1;
      @(posedge clk_i);
      if (i % 5 == 4) begin
        tx_bit_req_o <= 1'b0;
        @(posedge clk_i);
      end
    end
    tx_bit_req_o <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : tx_ident
  // One overhead byte, bit 7 first; released line shows the inverse
  task automatic rx_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      rx_bit_valid_o <= 1'b1;
      rx_first_bit_o <= (i == 7);
      rx_bit_o <= b[i];
      @(posedge clk_i);
      if (i % 2 == 1) begin
        rx_bit_valid_o <= 1'b0;
        rx_bit_o <= ~b[i];
        @(posedge clk_i);
      end
    end
    rx_bit_valid_o <= 1'b0;
    rx_first_bit_o <= 1'b0;
    rx_bit_o <= ~b[0];
    @(posedge clk_i);
  endtask : rx_byte
endmodule : trace_framer_model

// File: tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_i, cyc, stb, we, ack, defect, req, bval, bfirst, rbit, tbit, bv;
  logic [9:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [7:0] tbyte;
  logic [7:0] id[16];
  logic [7:0] txid[16];
  logic [15:0] rq[$];
  logic [7:0] tq[$];
  int n_fail = 0;
  int check_count = 0;
  int seed = 28859;
  trail_trace_processor dut_u (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .tx_bit_req_i(req), .tx_bit_o(tbit), .rx_bit_valid_i(bval), .rx_first_bit_i(bfirst),
    .rx_bit_i(rbit), .rx_defect_i(defect));
  trace_framer_model fm_u (.clk_i, .tx_bit_i(tbit), .tx_bit_req_o(req), .rx_bit_valid_o(bval),
    .rx_first_bit_o(bfirst), .rx_bit_o(rbit), .tx_byte_o(tbyte), .tx_byte_v_o(bv));
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic flag(input string m);
    n_fail++;
    $display("unexpected at %0t: %s", $time, m);
  endtask : flag
  task automatic cmp_rd(input logic [31:0] g);
    logic [15:0] e;
    check_count++;
    if (rq.size() == 0) flag("read without note");
    else begin
      e = rq.pop_front();
      if ((g & {24'hFF_FFFF, e[15:8]}) !== {24'h00_0000, e[7:0]}) flag("read data");
    end
  endtask : cmp_rd
  task automatic cmp_tx(input logic [7:0] g);
    check_count++;
    if (tq.size() == 0 || tq.pop_front() !== g) flag("tx byte");
  endtask : cmp_tx
  // Watcher: oldest note against each result
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) cmp_rd(rdat);
    if (bv === 1'b1) cmp_tx(tbyte);
  end
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [3:0] s);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= {24'h00_0000, d};
    // Hold the request until ack is seen; only the watchdog ends a hang
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic rd(input logic [9:0] a, input logic [7:0] v, input logic [7:0] m);
    rq.push_back({m, v});
    bus(1'b0, a, 8'h00, 4'hF);
  endtask : rd
  function automatic logic [9:0] at(input logic [2:0] r, input int i);
    return {1'b0, r, 6'(4 * i)};
  endfunction : at
  function automatic logic [7:0] rev(input logic [7:0] b);
    for (int j = 0; j < 8; j++) rev[j] = b[7 - j];
  endfunction : rev
  function automatic logic [7:0] tx_exp(input logic [7:0] b, input int i, input logic [3:0] c);
    tx_exp = c[0] ? rev(b) : b;
    if (c[1]) tx_exp[7] = (i == 0);
    if (c[2]) tx_exp = ~tx_exp;
    if (c[3]) tx_exp = 8'h00;
  endfunction : tx_exp
  task automatic send(input int n, input logic inv);
    repeat (n) for (int i = 0; i < 16; i++) fm_u.rx_byte(id[i] ^ {8{inv}});
  endtask : send
  task automatic new_id(input logic z);
    for (int i = 0; i < 16; i++) id[i] = z ? 8'h00 : 8'($random(seed)) & 8'h7F;
    id[0] = id[0] | 8'h80;
  endtask : new_id
  task automatic end_sim();
    if (rq.size() + tq.size() != 0) flag("results missing");
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  // Watchdog
  initial begin
    #1000000;
    flag("timeout");
    end_sim();
  end
  // Main sequence
  initial begin
    {cyc, stb, we, defect, adr, sel, wdat} = '0;
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b1, trail_trace_pkg::CTRL_OFS, 8'hFF, 4'h0);
    bus(1'b1, 10'h200, 8'hFF, 4'h1);
    rd(10'h200, 8'h00, 8'hFF);
    rd(trail_trace_pkg::CTRL_OFS, 8'h00, 8'hFF);
    // Compare on before any accepted identifier: no mismatch yet
    bus(1'b1, trail_trace_pkg::CTRL_OFS, 8'hA0, 4'h1);
    rd(trail_trace_pkg::STATUS_OFS, 8'h00, 8'hFF);
    for (int i = 0; i < 16; i++) begin
      txid[i] = 8'($random(seed));
      bus(1'b1, at(trail_trace_pkg::TX_REGION, i), txid[i], 4'h1);
    end
    for (int k = 0; k < 17; k++) begin
      if (k == 16) begin
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
      end else bus(1'b1, trail_trace_pkg::CTRL_OFS, 8'(k), 4'h1);
      for (int i = 0; i < 16; i++) tq.push_back(tx_exp(txid[i], i, 4'(k % 16)));
      fm_u.tx_ident();
    end
    new_id(1'b0);
    bus(1'b1, trail_trace_pkg::CTRL_OFS, 8'h20, 4'h1);
    send(7, 1'b0);
    for (int i = 0; i < 16; i++) begin
      rd(at(trail_trace_pkg::ACC_REGION, i), id[i], 8'hFF);
      bus(1'b1, at(trail_trace_pkg::EXP_REGION, i), id[i], 4'h1);
    end
    rd(trail_trace_pkg::EVENT_OFS, 8'h01, 8'h01);
    bus(1'b1, trail_trace_pkg::EVENT_OFS, 8'h0F, 4'h1);
    rd(trail_trace_pkg::EVENT_OFS, 8'h00, 8'hFF);
    bus(1'b1, trail_trace_pkg::CTRL_OFS, 8'hA0, 4'h1);
    rd(trail_trace_pkg::STATUS_OFS, 8'h10, 8'h18);
    bus(1'b1, at(trail_trace_pkg::EXP_REGION, 3), id[3] ^ 8'h80, 4'h1);
    rd(trail_trace_pkg::STATUS_OFS, 8'h00, 8'h08);
    bus(1'b1, at(trail_trace_pkg::EXP_REGION, 3), id[3] ^ 8'h01, 4'h1);
    rd(at(trail_trace_pkg::EXP_REGION, 3), id[3] ^ 8'h01, 8'hFF);
    rd(trail_trace_pkg::STATUS_OFS, 8'h08, 8'h08);
    bus(1'b1, trail_trace_pkg::CTRL_OFS, 8'h80, 4'h1);
    rd(trail_trace_pkg::STATUS_OFS, 8'h00, 8'h08);
    bus(1'b1, trail_trace_pkg::CTRL_OFS, 8'h20, 4'h1);
    new_id(1'b1);
    send(6, 1'b0);
    rd(trail_trace_pkg::STATUS_OFS, 8'h02, 8'h06);
    rd(trail_trace_pkg::EVENT_OFS, 8'h02, 8'h02);
    for (int n = 0; n < 9; n++) begin
      new_id(1'b0);
      send(1, 1'b0);
    end
    rd(trail_trace_pkg::STATUS_OFS, 8'h04, 8'h06);
    bus(1'b1, trail_trace_pkg::CTRL_OFS, 8'h70, 4'h1);
    send(2, 1'b1);
    for (int i = 0; i < 16; i++) rd(at(trail_trace_pkg::CUR_REGION, i), rev(id[i]), 8'hFF);
    bus(1'b1, trail_trace_pkg::CTRL_OFS, 8'h00, 4'h1);
    defect <= 1'b1;
    send(1, 1'b0);
    defect <= 1'b0;
    for (int i = 0; i < 16; i++) rd(at(trail_trace_pkg::CUR_REGION, i), 8'hFF, 8'hFF);
    repeat (4) @(posedge clk_i);
    end_sim();
  end
endmodule : tb
